//--- tws_pkg.sv
package tws_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int DEPTH = 256;
    localparam int PAGE_BITS = 3;
    localparam logic [3:0] DEV_TYPE = 4'hA;
    localparam int CLK_HZ = 10000000;
    localparam int WR_TIME_US = 5000;
    localparam int WR_CYCLES = (WR_TIME_US * (CLK_HZ / 1000000));
    localparam logic [7:0] ADDR_RST = 8'h00;

    typedef enum logic [5:0] {
        TWS_IDLE = 6'b000001,
        TWS_DEV = 6'b000010,
        TWS_WADDR = 6'b000100,
        TWS_WDATA = 6'b001000,
        TWS_RDATA = 6'b010000,
        TWS_RACK = 6'b100000
    } tws_state_t;

    typedef struct packed {
        logic start;
        logic stop;
        logic rise;
        logic fall;
    } tws_bus_ev_t;
endpackage

//--- tws_eeprom.sv
`timescale 1ns/1ps
// What this block does
// - data falling with clock high is a start; every command needs one
// - data rising with clock high is a stop; after a read it means standby
// - words are 8 bits; device pulls data low on ninth clock to acknowledge
// - standby at power-up and after stop once internal work is done
// - after start take 8-bit device word; top four bits match fixed type
// - next three bits must equal the three chip-select pins
// - eighth bit high means read, low means write
// - match is acknowledged low; mismatch is ignored and device goes standby
// - byte write: device word, word address, one data byte, each acknowledged, stop
// - stop after write starts timed write; inputs ignored meanwhile
// - page write: up to seven more data bytes, each acknowledged, then stop
// - write increments only low three address bits, wrapping within the page
// - during write cycle a device address gets no acknowledge
// - address counter holds next address between operations: last read plus one, last write plus one within the page
// - reads wrap from last byte of last page to first byte
// - current read shifts out byte at counter; master nacks then stops
// - sequential read continues while master acknowledges each byte
// - write-protect high blocks writes to the upper half of the array
// - storage is 32 pages of 8 bytes with an 8-bit word address
module tws_eeprom #(
    parameter int WR_CYC = tws_pkg::WR_CYCLES
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    input wire logic chip_select_pin_2,
    input wire logic chip_select_pin_1,
    input wire logic chip_select_pin_0,
    input wire logic wp,
    output logic busy,
    output logic standby
);
    logic [1:0] scl_sync_reg;
    logic [1:0] sda_sync_reg;
    logic [2:0] cs_sync0_reg;
    logic [2:0] cs_sync_reg;
    logic [1:0] wp_sync_reg;
    logic scl_d_reg;
    logic sda_d_reg;
    tws_pkg::tws_bus_ev_t ev;
    tws_pkg::tws_state_t state_reg;
    logic [3:0] bit_reg;
    logic [7:0] sh_reg;
    logic ack_phase_reg;
    logic rd_reg;
    logic [7:0] addr_reg;
    logic [7:0] mem_reg [tws_pkg::DEPTH];
    logic [7:0] pbuf_reg [8];
    logic [7:0] pvalid_reg;
    logic [7:0] page_reg;
    logic wr_pend_reg;
    logic [31:0] wcnt_reg;
    logic wr_active;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            scl_sync_reg <= 2'h3;
            sda_sync_reg <= 2'h3;
            cs_sync0_reg <= 3'h0;
            cs_sync_reg <= 3'h0;
            wp_sync_reg <= 2'h0;
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end else begin
            scl_sync_reg <= {scl_sync_reg[0], scl};
            sda_sync_reg <= {sda_sync_reg[0], sda_in};
            cs_sync0_reg <= {chip_select_pin_2, chip_select_pin_1, chip_select_pin_0};
            cs_sync_reg <= cs_sync0_reg;
            wp_sync_reg <= {wp_sync_reg[0], wp};
            scl_d_reg <= scl_sync_reg[1];
            sda_d_reg <= sda_sync_reg[1];
        end
    end

    always_comb begin
        ev.start = scl_d_reg && scl_sync_reg[1] && sda_d_reg && !sda_sync_reg[1];
        ev.stop = scl_d_reg && scl_sync_reg[1] && !sda_d_reg && sda_sync_reg[1];
        ev.rise = !scl_d_reg && scl_sync_reg[1];
        ev.fall = scl_d_reg && !scl_sync_reg[1];
    end

    assign wr_active = wcnt_reg != 32'h0;

    // protocol engine
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= tws_pkg::TWS_IDLE;
            bit_reg <= 4'h0;
            sh_reg <= 8'h00;
            ack_phase_reg <= 1'b0;
            rd_reg <= 1'b0;
            addr_reg <= tws_pkg::ADDR_RST;
            sda_out <= 1'b1;
            sda_oe_n <= 1'b1;
            pvalid_reg <= 8'h00;
            page_reg <= 8'h00;
            wr_pend_reg <= 1'b0;
            standby <= 1'b1;
        end else if (wr_active) begin
            sda_oe_n <= 1'b1;
            sda_out <= 1'b1;
            wr_pend_reg <= 1'b0;
            state_reg <= tws_pkg::TWS_IDLE;
        end else if (ev.start) begin
            state_reg <= tws_pkg::TWS_DEV;
            bit_reg <= 4'h0;
            ack_phase_reg <= 1'b0;
            sda_oe_n <= 1'b1;
            sda_out <= 1'b1;
            standby <= 1'b0;
        end else if (ev.stop) begin
            state_reg <= tws_pkg::TWS_IDLE;
            sda_oe_n <= 1'b1;
            sda_out <= 1'b1;
            wr_pend_reg <= pvalid_reg != 8'h00;
            standby <= pvalid_reg == 8'h00;
        end else if (ev.rise && state_reg != tws_pkg::TWS_IDLE) begin
            // while sending, the shifter holds the outgoing byte and bits count on falls
            if (!ack_phase_reg && state_reg != tws_pkg::TWS_RDATA) begin
                sh_reg <= {sh_reg[6:0], sda_sync_reg[1]};
                bit_reg <= bit_reg + 4'h1;
            end else if (state_reg == tws_pkg::TWS_RACK) begin
                // master ack continues read, nack ends it
                if (sda_sync_reg[1]) begin
                    state_reg <= tws_pkg::TWS_IDLE;
                end else begin
                    state_reg <= tws_pkg::TWS_RDATA;
                end
            end
        end else if (ev.fall && state_reg != tws_pkg::TWS_IDLE) begin
            if (ack_phase_reg) begin
                ack_phase_reg <= 1'b0;
                bit_reg <= 4'h0;
                sda_oe_n <= 1'b1;
                sda_out <= 1'b1;
                if (state_reg == tws_pkg::TWS_RDATA || (state_reg == tws_pkg::TWS_RACK
                        && !sda_d_reg)) begin
                    sda_oe_n <= ~mem_reg[addr_reg][7] ? 1'b0 : 1'b1;
                    sda_out <= mem_reg[addr_reg][7];
                    sh_reg <= mem_reg[addr_reg];
                    bit_reg <= 4'h1;
                    state_reg <= tws_pkg::TWS_RDATA;
                end
            end else if (state_reg == tws_pkg::TWS_RDATA) begin
                if (bit_reg == 4'h8) begin
                    sda_oe_n <= 1'b1;
                    sda_out <= 1'b1;
                    addr_reg <= addr_reg + 8'h01;
                    ack_phase_reg <= 1'b1;
                    state_reg <= tws_pkg::TWS_RACK;
                end else begin
                    sda_oe_n <= sh_reg[6 - 32'(bit_reg - 4'h1)] ? 1'b1 : 1'b0;
                    sda_out <= sh_reg[6 - 32'(bit_reg - 4'h1)];
                    bit_reg <= bit_reg + 4'h1;
                end
            end else if (bit_reg == 4'h8) begin
                ack_phase_reg <= 1'b1;
                unique case (state_reg)
                    tws_pkg::TWS_DEV: begin
                        if (sh_reg[7:4] == tws_pkg::DEV_TYPE
                                && sh_reg[3:1] == cs_sync_reg) begin
                            sda_oe_n <= 1'b0;
                            sda_out <= 1'b0;
                            rd_reg <= sh_reg[0];
                            state_reg <= sh_reg[0] ? tws_pkg::TWS_RDATA
                                                   : tws_pkg::TWS_WADDR;
                        end else begin
                            state_reg <= tws_pkg::TWS_IDLE;
                            standby <= 1'b1;
                        end
                    end
                    tws_pkg::TWS_WADDR: begin
                        sda_oe_n <= 1'b0;
                        sda_out <= 1'b0;
                        addr_reg <= sh_reg;
                        page_reg <= sh_reg;
                        pvalid_reg <= 8'h00;
                        state_reg <= tws_pkg::TWS_WDATA;
                    end
                    tws_pkg::TWS_WDATA: begin
                        sda_oe_n <= 1'b0;
                        sda_out <= 1'b0;
                        pbuf_reg[addr_reg[2:0]] <= sh_reg;
                        pvalid_reg[addr_reg[2:0]] <= 1'b1;
                        addr_reg <= {addr_reg[7:3], addr_reg[2:0] + 3'h1};
                    end
                    default: begin
                        state_reg <= tws_pkg::TWS_IDLE;
                    end
                endcase
            end
        end
        if (wcnt_reg == 32'h1) begin
            pvalid_reg <= 8'h00;
            standby <= 1'b1;
        end
    end

    // timed write cycle
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            wcnt_reg <= 32'h0;
            busy <= 1'b0;
        end else if (wr_pend_reg) begin
            wcnt_reg <= 32'(WR_CYC);
            busy <= 1'b1;
        end else if (wr_active) begin
            wcnt_reg <= wcnt_reg - 32'h1;
            busy <= wcnt_reg != 32'h1;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_commit
            always_ff @(posedge mclk) begin
                if (wcnt_reg == 32'h1 && pvalid_reg[gi]
                        && !(wp_sync_reg[1] && page_reg[7])) begin
                    mem_reg[{page_reg[7:3], 3'(gi)}] <= pbuf_reg[gi];
                end
            end
        end
    endgenerate

    a_busy_silent: assert property (@(posedge mclk) disable iff (!arst_n)
        busy |=> sda_oe_n);
    a_start_dev: assert property (@(posedge mclk) disable iff (!arst_n)
        (ev.start && !wr_active) |=> state_reg == tws_pkg::TWS_DEV);
    a_stop_idle: assert property (@(posedge mclk) disable iff (!arst_n)
        (ev.stop && !wr_active) |=> state_reg == tws_pkg::TWS_IDLE);
    a_write_start: assert property (@(posedge mclk) disable iff (!arst_n)
        wr_pend_reg |=> busy);
    a_page_wrap: assert property (@(posedge mclk) disable iff (!arst_n)
        (state_reg == tws_pkg::TWS_WDATA) |=> addr_reg[7:3] == $past(addr_reg[7:3]));
    a_count_len: assert property (@(posedge mclk) disable iff (!arst_n)
        $rose(busy) |-> wcnt_reg == 32'(WR_CYC));
    a_idle_release: assert property (@(posedge mclk) disable iff (!arst_n)
        (state_reg == tws_pkg::TWS_IDLE && !ev.start) |=> sda_oe_n);
    a_mismatch_nack: assert property (@(posedge mclk) disable iff (!arst_n)
        (ev.fall && state_reg == tws_pkg::TWS_DEV && bit_reg == 4'h8 && !ack_phase_reg
         && sh_reg[7:4] != tws_pkg::DEV_TYPE && !wr_active && !ev.start && !ev.stop)
        |=> sda_oe_n && state_reg == tws_pkg::TWS_IDLE);

    // device word fully shifted in, and its match against type and pins
    sequence s_dev_word_end;
        ev.fall && state_reg == tws_pkg::TWS_DEV && bit_reg == 4'h8 && !ack_phase_reg
            && !wr_active;
    endsequence
    sequence s_dev_match;
        sh_reg[7:4] == tws_pkg::DEV_TYPE && sh_reg[3:1] == cs_sync_reg;
    endsequence

    a_match_ack: assert property (@(posedge mclk) disable iff (!arst_n)
        (s_dev_word_end and s_dev_match) |=> !sda_oe_n && state_reg != tws_pkg::TWS_IDLE)
        else $error("matched device word not acknowledged");
    a_dir_select: assert property (@(posedge mclk) disable iff (!arst_n)
        (s_dev_word_end and s_dev_match) |=> rd_reg == $past(sh_reg[0]))
        else $error("direction bit not taken");
    a_read_first: assert property (@(posedge mclk) disable iff (!arst_n)
        (s_dev_word_end and s_dev_match and sh_reg[0]) |=> state_reg == tws_pkg::TWS_RDATA)
        else $error("read direction did not start a read");
    a_ack_hold: assert property (@(posedge mclk) disable iff (!arst_n)
        (ack_phase_reg && !sda_oe_n && !ev.fall && !wr_active && !ev.start && !ev.stop)
        |=> !sda_oe_n)
        else $error("acknowledge dropped before clock fall");
    a_stop_commit: assert property (@(posedge mclk) disable iff (!arst_n)
        (ev.stop && !wr_active && pvalid_reg != 8'h00) |=> wr_pend_reg)
        else $error("stop after data did not start write");
    a_dummy_write: assert property (@(posedge mclk) disable iff (!arst_n)
        (ev.stop && !wr_active && pvalid_reg == 8'h00) |=> !wr_pend_reg)
        else $error("stop without data started write");
    a_poll_nack: assert property (@(posedge mclk) disable iff (!arst_n)
        wr_active |=> sda_oe_n)
        else $error("line driven during write cycle");
    a_byte_wrap: assert property (@(posedge mclk) disable iff (!arst_n)
        (ev.fall && state_reg == tws_pkg::TWS_WDATA && bit_reg == 4'h8 && !ack_phase_reg
         && !wr_active) |=> addr_reg[2:0] == $past(addr_reg[2:0]) + 3'h1)
        else $error("page offset not advanced");
    a_read_step: assert property (@(posedge mclk) disable iff (!arst_n)
        (ev.fall && state_reg == tws_pkg::TWS_RDATA && bit_reg == 4'h8 && !ack_phase_reg
         && !wr_active) |=> addr_reg == $past(addr_reg) + 8'h01)
        else $error("address counter not advanced after read");
    a_read_wrap: assert property (@(posedge mclk) disable iff (!arst_n)
        (ev.fall && state_reg == tws_pkg::TWS_RDATA && bit_reg == 4'h8 && !ack_phase_reg
         && !wr_active && addr_reg == 8'hFF) |=> addr_reg == 8'h00)
        else $error("read address did not wrap to zero");
    a_nack_end: assert property (@(posedge mclk) disable iff (!arst_n)
        (ev.rise && state_reg == tws_pkg::TWS_RACK && ack_phase_reg && sda_sync_reg[1]
         && !wr_active) |=> state_reg == tws_pkg::TWS_IDLE)
        else $error("read not ended by master nack");
    a_ack_more: assert property (@(posedge mclk) disable iff (!arst_n)
        (ev.rise && state_reg == tws_pkg::TWS_RACK && ack_phase_reg && !sda_sync_reg[1]
         && !wr_active) |=> state_reg == tws_pkg::TWS_RDATA)
        else $error("read not continued after master ack");
    a_commit_standby: assert property (@(posedge mclk) disable iff (!arst_n)
        (wcnt_reg == 32'h1) |=> standby && !busy)
        else $error("no standby after write cycle");
    a_busy_hold: assert property (@(posedge mclk) disable iff (!arst_n)
        (busy && wcnt_reg != 32'h1) |=> busy)
        else $error("write cycle ended early");
    a_start_release: assert property (@(posedge mclk) disable iff (!arst_n)
        (ev.start && !wr_active) |=> sda_oe_n)
        else $error("line still driven after start");
endmodule

//--- tws_master.sv
`timescale 1ns/1ps
module tws_master (
    input wire logic mclk,
    input wire logic sda_line,
    output logic scl = 1'b1,
    output logic sda_drv = 1'b1
);
    task automatic step(input logic c, input logic d, input int n);
        scl <= c;
        sda_drv <= d;
        repeat (n) @(posedge mclk);
    endtask
    // each cell drops the clock first, so data only moves while it is low
    task automatic bit_io(input logic b, output logic r);
        step(1'b0, sda_drv, 1);
        step(1'b0, b, 3);
        step(1'b1, b, 2);
        r = sda_line;
        step(1'b1, b, 2);
    endtask
    // start when stop is low, stop when high; clock rests high afterwards
    task automatic frame(input logic stop);
        step(1'b0, sda_drv, 1);
        step(1'b0, !stop, 3);
        step(1'b1, !stop, 4);
        step(1'b1, stop, 4);
    endtask
    task automatic send(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(b[i], r);
        bit_io(1'b1, ack);
    endtask
    task automatic recv(output logic [7:0] b, input logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            b[i] = r;
        end
        bit_io(ack, r);
    endtask
endmodule

//--- testbench.sv
`timescale 1ns/1ps
module testbench;
    // each row: word address above, data byte below
    logic [15:0] rows [5] = '{16'h005A, 16'h01C3, 16'h7F96, 16'h803C, 16'hFFA5};
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic wp = 1'b0;
    logic ack;
    logic [2:0] cs_pins = 3'h5;
    logic [7:0] cur = 8'h00;
    logic [7:0] mem [256];
    logic scl, sda_drv, sda_out, sda_oe_n, busy, standby;
    int bad_count = 0;
    int compares = 0;
    wire sda_in = sda_drv & (sda_oe_n | sda_out);
    always #50 mclk = ~mclk;
    tws_eeprom #(.WR_CYC(150)) tws_eeprom_i (.mclk(mclk), .arst_n(arst_n), .scl(scl),
        .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .wp(wp), .busy(busy),
        .chip_select_pin_2(cs_pins[2]), .chip_select_pin_1(cs_pins[1]),
        .chip_select_pin_0(cs_pins[0]), .standby(standby));
    tws_master tws_master_i (.mclk(mclk), .sda_line(sda_in), .scl(scl), .sda_drv(sda_drv));
    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic report_and_stop;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    function automatic logic [7:0] dw(input logic rw);
        return {tws_pkg::DEV_TYPE, cs_pins, rw};
    endfunction
    task automatic dev(input logic [7:0] w, input logic exp);
        tws_master_i.frame(1'b0);
        tws_master_i.send(w, ack);
        check("device ack", {7'h00, ack}, {7'h00, exp});
    endtask
    task automatic do_write(input logic [7:0] a, input logic [7:0] d [$]);
        dev(dw(1'b0), 1'b0);
        tws_master_i.send(a, ack);
        check("word addr ack", {7'h00, ack}, 8'h00);
        foreach (d[i]) begin
            tws_master_i.send(d[i], ack);
            check("data ack", {7'h00, ack}, 8'h00);
            if (!(wp && a[7]))
                mem[{a[7:3], a[2:0] + 3'(i)}] = d[i];
        end
        tws_master_i.frame(1'b1);
        @(posedge mclk);
        check("busy after stop", {7'h00, busy}, 8'h01);
        dev(dw(1'b0), 1'b1);
        for (int n = 0; n < 6 && ack !== 1'b0; n++) begin
            tws_master_i.frame(1'b0);
            tws_master_i.send(dw(1'b0), ack);
        end
        tws_master_i.frame(1'b1);
        check("poll ack", {7'h00, ack}, 8'h00);
    endtask
    task automatic do_read(input logic [7:0] a, input int n, input logic rnd);
        logic [7:0] b;
        if (rnd) begin
            dev(dw(1'b0), 1'b0);
            tws_master_i.send(a, ack);
            cur = a;
        end
        dev(dw(1'b1), 1'b0);
        for (int i = 0; i < n; i++) begin
            tws_master_i.recv(b, i == n - 1);
            check("read data", b, mem[cur]);
            cur++;
        end
        tws_master_i.frame(1'b1);
    endtask
    initial begin
        repeat (4) @(posedge mclk);
        check("idle in reset", {6'h00, sda_oe_n, standby}, 8'h03);
        arst_n <= 1'b1;
        repeat (4) @(posedge mclk);
        foreach (rows[i]) begin
            do_write(rows[i][15:8], '{rows[i][7:0]});
            do_read(rows[i][15:8], 1, 1'b1);
        end
        dev({4'h5, cs_pins, 1'b0}, 1'b1);
        dev({tws_pkg::DEV_TYPE, ~cs_pins, 1'b0}, 1'b1);
        tws_master_i.frame(1'b1);
        do_write(8'h1D, '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09,
            8'h0A});
        do_read(8'h18, 8, 1'b1);
        do_read(8'hFF, 2, 1'b1);
        do_read(8'h00, 1, 1'b0);
        wp <= 1'b1;
        do_write(8'h80, '{8'hE7});
        do_read(8'h80, 1, 1'b1);
        wp <= 1'b0;
        cs_pins <= 3'h2;
        repeat (4) @(posedge mclk);
        do_write(8'h80, '{8'hE7});
        do_read(8'h80, 1, 1'b1);
        repeat (4) @(posedge mclk);
        check("standby after read", {7'h00, standby}, 8'h01);
        report_and_stop;
    end
endmodule
